// ===== src/uisc_pkg.sv
// Notes on behaviour
// RL1: receiver status error raises level one, code 000110
// RL2: nine-bit mode masks errors with modem enable
// RL3: rx data available above trigger level
// RL4: fifo timeout after four characters, code 001100
// RL5: tx empty below trigger, cleared by read
// RL6: trigger zero waits for line idle
// RL7: modem change flag raises level four
// RL8: enhanced flow-stop or special character, level five
// RL9: cts or rts rising raises level six
// RL10: sleep only when every condition holds
// RL11: sleep bit reads back actual sleep state
// RL12: sleep exits when any condition fails
// RL13: dtr and rts pins are inverted bits
// RL14: user outputs, bit three gates interrupt
// RL15: loopback idles outputs and internally loops
// RL16: loopback modem changes come from control bits
// RL17: bit five is xon-any or auto flow
// RL18: bit six selects infrared, enhanced only
// RL19: bit seven prescaler select, enhanced writes only
// RL20: delta bits latch changes, ri only when it goes inactive, cleared on read
// RL21: status high nibble is inverted modem inputs
// RL22: divisor is low plus 256 times high
// RL23: six priority levels, highest reported only
// RL24: bit zero set means nothing pending
// RL25: modem inputs synchronised before edge detection
package uisc_pkg;
   // register word offsets on the avalon bus
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MODEM_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_MODEM_STATUS = 4'h3;
   localparam logic [3:0] ADDR_DIVISOR_LOW = 4'h4;
   localparam logic [3:0] ADDR_DIVISOR_HIGH = 4'h5;
   localparam logic [3:0] ADDR_MODE_CTRL = 4'h6;
   localparam logic [3:0] ADDR_PRESCALER = 4'h7;
   localparam logic [3:0] ADDR_LINE_STATUS = 4'h8;
   // interrupt identification codes
   localparam logic [5:0] CODE_NONE = 6'h01;
   localparam logic [5:0] CODE_RX_STATUS = 6'h06;
   localparam logic [5:0] CODE_RX_DATA = 6'h04;
   localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
   localparam logic [5:0] CODE_TX_EMPTY = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_SPECIAL = 6'h10;
   localparam logic [5:0] CODE_HANDSHAKE = 6'h20;
   // reset values
   localparam logic [7:0] PRESCALER_RESET = 8'h20;
   localparam logic [7:0] DIVISOR_LOW_RESET = 8'h01;
   localparam logic [7:0] DIVISOR_HIGH_RESET = 8'h00;
   // irq_enable bit positions
   localparam int IE_RX_DATA = 0;
   localparam int IE_TX_EMPTY = 1;
   localparam int IE_RX_STATUS = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_SLEEP = 4;
   localparam int IE_SPECIAL = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   // modem_control bit positions
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_USER_OUT_ONE_N = 2;
   localparam int MC_USER_OUT_TWO_N = 3;
   localparam int MC_LOOP = 4;
   localparam int MC_XANY = 5;
   localparam int MC_INFRARED = 6;
   localparam int MC_PRESCALE = 7;
   // mode control bits (enhanced, nine-bit, fifo, nine-bit addr enable, fine trigger)
   localparam int MD_ENHANCED = 0;
   localparam int MD_NINE_BIT = 1;
   localparam int MD_FIFO = 2;
   localparam int MD_ADDR_IE = 3;
   localparam int MD_FINE_TRIG = 4;
   // timeout length in character periods
   localparam int TIMEOUT_CHARS = 4;
   // receiver samples per bit
   localparam int SAMPLES_PER_BIT = 16;
   // time-out counter width, holds 640 times the largest divisor
   localparam int TO_CNT_W = 26;

   // events coming from the receiver and transmitter datapaths
   typedef struct packed {
      logic overrun;      // line status overrun
      logic parity;       // parity or ninth bit
      logic framing;      // framing error
      logic brk;          // break
      logic rx_level_hi;  // fifo above trigger
      logic rx_has_data;  // holding register not empty
      logic rx_idle;      // receiver idle
      logic rx_read;      // holding register read pulse
      logic rx_write;     // new item written pulse
      logic tx_level_lo;  // tx fifo below trigger
      logic tx_fifo_empty;
      logic tx_shift_empty;
      logic tx_ttl_zero;  // tx trigger level set to zero
      logic flow_stop;    // valid flow-stop char with in-band on
      logic stop_two;     // second stop char match with detect on
      logic nine_special; // nine-bit special char match
   } uisc_events_type;

   // modem control outputs toward the pins
   typedef struct packed {
      logic dtr_n;
      logic rts_n;
      logic user_out_one_n;
      logic user_out_two_n;
      logic serial_out;
   } uisc_modem_pins_type;

   // highest-priority pending code, returns none when idle
   function automatic logic [5:0] prio_code(input logic [6:0] p);
      if (p[0]) return CODE_RX_STATUS;
      else if (p[1]) return CODE_RX_DATA;
      else if (p[2]) return CODE_TIMEOUT;
      else if (p[3]) return CODE_TX_EMPTY;
      else if (p[4]) return CODE_MODEM;
      else if (p[5]) return CODE_SPECIAL;
      else if (p[6]) return CODE_HANDSHAKE;
      else return CODE_NONE;
   endfunction
endpackage

// ===== src/uisc_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bus of levels
module uisc_sync #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage_one; // read only by the second stage
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_sync;

   // next values; reset value is all-high, idle for active-low pins
   always_comb begin
      next_stage_one = srst_i ? '1 : async_i;
      next_sync = srst_i ? '1 : stage_one;
   end

   always_ff @(posedge ref_clk_i) begin
      stage_one <= next_stage_one;
      sync_o <= next_sync;
   end
endmodule // uisc_sync

// ===== src/uisc_timeout.sv
`timescale 1ns/1ps
// receive time-out counter, four character periods of silence
module uisc_timeout
   import uisc_pkg::*;
#(
   parameter int CNT_W = 26
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic enable_i,       // fifo mode and data held
   input wire logic restart_i,      // read or new write pulse
   input wire logic [CNT_W-1:0] limit_i, // cycles for four characters
   output logic expired_o
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic next_expired;

   // count idle cycles; any read or write restarts the window
   always_comb begin
      next_count = count;
      next_expired = expired_o;
      if (srst_i || !enable_i || restart_i) begin
         next_count = '0;
         next_expired = 1'b0; // RL4
      end else if (count >= limit_i) begin
         next_expired = 1'b1; // RL4
      end else begin
         next_count = count + CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      count <= next_count;
      expired_o <= next_expired;
   end
endmodule // uisc_timeout

// ===== src/uisc_ctrl.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module uisc_ctrl
   import uisc_pkg::*;
#(
   parameter int BITS_PER_CHAR = 10  // start, data and stop bits
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // datapath events
   input wire uisc_pkg::uisc_events_type events_i,
   input wire logic tx_serial_i,     // transmitter output bit
   input wire logic serial_in_i,
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic dcd_n_i,
   input wire logic int_sel_n_i,     // interrupt mode select pin
   output uisc_pkg::uisc_modem_pins_type pins_o,
   output logic rx_serial_o,         // receiver input after loopback mux
   output logic irq_o,               // channel interrupt level
   output logic irq_oe_o,            // interrupt output enable
   output logic clk_gate_o,          // high while channel clock runs
   output logic [15:0] divisor_o,
   output logic [7:0] prescaler_o,
   output logic prescale_sel_o,
   output logic infrared_o,
   output logic auto_flow_o,         // cts/rts auto flow, non-enhanced
   output logic xon_any_o
);
   import uisc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] irq_enable;
   logic [7:0] modem_control;
   logic [7:0] mode_ctrl;
   logic [7:0] divisor_low;
   logic [7:0] divisor_high;
   logic [7:0] prescaler_setting;
   logic [3:0] delta;           // modem change flags
   logic [3:0] line_err;        // overrun, parity, framing, break
   logic tx_flag;               // level three latched
   logic special_flag;          // level five latched
   logic hs_flag;               // level six latched
   logic asleep;
   logic [5:0] irq_code;
   logic [3:0] modem_prev;      // previous effective modem lines
   logic rts_prev;
   logic tx_set_prev;           // transmit set condition last cycle
   logic [7:0] next_irq_enable, next_modem_control, next_mode_ctrl;
   logic [7:0] next_divisor_low, next_divisor_high, next_prescaler;
   logic [3:0] next_delta, next_line_err, next_modem_prev;
   logic next_tx_flag, next_special_flag, next_hs_flag, next_asleep;
   logic next_rts_prev, next_tx_set_prev;
   logic [5:0] next_irq_code;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   uisc_modem_pins_type next_pins;
   logic next_rx_serial, next_irq, next_irq_oe;

   ////////////////////////////////////////////////////////////////////
   // modem input synchroniser, order cts dsr ri dcd
   logic [3:0] modem_sync;
   uisc_sync #(.WIDTH(4)) u_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i({dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
      .sync_o(modem_sync)
   ); // RL25

   // time-out: four characters of sixteen clocks per bit times divisor
   logic to_expired;
   logic [TO_CNT_W-1:0] to_limit;
   assign to_limit = TO_CNT_W'(TIMEOUT_CHARS * BITS_PER_CHAR * SAMPLES_PER_BIT)
      * TO_CNT_W'({divisor_high, divisor_low}); // RL4 RL22
   uisc_timeout #(.CNT_W(TO_CNT_W)) u_timeout (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .enable_i(mode_ctrl[MD_FIFO] && events_i.rx_has_data),
      .restart_i(events_i.rx_read || events_i.rx_write),
      .limit_i(to_limit),
      .expired_o(to_expired)
   );

   ////////////////////////////////////////////////////////////////////
   // derived conditions
   logic enhanced, nine, loop;
   logic [3:0] lines;     // active-high modem lines, cts dsr ri dcd
   logic acc, rd_acc, wr_acc;
   logic [6:0] pending;
   logic sleep_req, sleep_ok;

   always_comb begin
      enhanced = mode_ctrl[MD_ENHANCED];
      nine = mode_ctrl[MD_NINE_BIT];
      loop = modem_control[MC_LOOP];
      // loopback feeds rts, dtr, user_out_one_n, user_out_two_n to cts, dsr, ri, dcd
      if (loop)
         lines = {modem_control[MC_USER_OUT_TWO_N], modem_control[MC_USER_OUT_ONE_N],
                  modem_control[MC_DTR], modem_control[MC_RTS]}; // RL15 RL16 RL21
      else
         lines = ~modem_sync; // RL21
      acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;
      rd_acc = acc && avs_read_i;
      wr_acc = acc && avs_write_i;
      // pending sources, index is priority order
      if (nine)
         pending[0] = ((|{line_err[3:2], line_err[0]}) && irq_enable[IE_MODEM])
            || (line_err[1] && mode_ctrl[MD_ADDR_IE]); // RL2
      else
         pending[0] = (|line_err) && irq_enable[IE_RX_STATUS]; // RL1
      pending[1] = events_i.rx_level_hi && irq_enable[IE_RX_DATA]; // RL3
      pending[2] = to_expired && irq_enable[IE_RX_DATA]; // RL4
      pending[3] = tx_flag && irq_enable[IE_TX_EMPTY]; // RL5
      pending[4] = (|delta) && irq_enable[IE_MODEM]; // RL7
      pending[5] = enhanced && special_flag && irq_enable[IE_SPECIAL]; // RL8
      pending[6] = hs_flag && (!enhanced
         || irq_enable[IE_RTS] || irq_enable[IE_CTS]); // RL9
      sleep_req = enhanced ? irq_enable[IE_SLEEP] : irq_enable[IE_SPECIAL];
      sleep_ok = sleep_req && events_i.tx_fifo_empty && events_i.tx_shift_empty
         && serial_in_i && events_i.rx_idle && !events_i.rx_has_data && !loop
         && (delta == 4'h0) && (pending == 7'h00)
         && !modem_control[MC_INFRARED]; // RL10 RL12
   end

   ////////////////////////////////////////////////////////////////////
   // register writes, flag updates and read data
   always_comb begin
      logic [7:0] rd;
      logic tx_set;
      rd = 8'h00;
      tx_set = 1'b0;
      next_irq_enable = irq_enable;
      next_modem_control = modem_control;
      next_mode_ctrl = mode_ctrl;
      next_divisor_low = divisor_low;
      next_divisor_high = divisor_high;
      next_prescaler = prescaler_setting;
      next_delta = delta;
      next_line_err = line_err;
      next_tx_flag = tx_flag;
      next_special_flag = special_flag;
      next_hs_flag = hs_flag;
      next_modem_prev = lines;
      next_rts_prev = modem_control[MC_RTS];
      next_irq_code = prio_code(pending); // RL23 RL24
      next_asleep = sleep_ok; // RL10 RL12
      // clears first so that same-cycle sets win below
      if (rd_acc) begin
         case (avs_address_i)
            ADDR_IRQ_ENABLE: rd = {irq_enable[7:6],
               enhanced ? irq_enable[IE_SPECIAL] : asleep,
               enhanced ? asleep : irq_enable[IE_SLEEP],
               irq_enable[3:0]}; // RL11
            ADDR_IRQ_STATUS: begin
               rd = {2'b00, irq_code};
               if (irq_code == CODE_TX_EMPTY) next_tx_flag = 1'b0; // RL5
               if (irq_code == CODE_SPECIAL) next_special_flag = 1'b0; // RL8
               if (irq_code == CODE_HANDSHAKE) next_hs_flag = 1'b0; // RL9
            end
            ADDR_MODEM_CONTROL: rd = modem_control;
            ADDR_MODEM_STATUS: begin
               rd = {lines[3], lines[2], lines[1], lines[0], delta}; // RL21
               next_delta = 4'h0; // RL20 RL7
            end
            ADDR_DIVISOR_LOW: rd = divisor_low;
            ADDR_DIVISOR_HIGH: rd = divisor_high;
            ADDR_MODE_CTRL: rd = mode_ctrl;
            ADDR_PRESCALER: rd = prescaler_setting;
            ADDR_LINE_STATUS: begin
               // summary bit: framing/break only in nine-bit mode
               rd = {nine ? (line_err[2] | line_err[3]) : (|line_err[3:1]),
                     events_i.tx_fifo_empty && events_i.tx_shift_empty,
                     events_i.tx_fifo_empty, line_err[3], line_err[2],
                     line_err[1], line_err[0], events_i.rx_has_data}; // RL2
               next_line_err = 4'h0; // RL1
            end
            default: rd = 8'h00;
         endcase
      end
      if (wr_acc) begin
         case (avs_address_i)
            ADDR_IRQ_ENABLE: next_irq_enable = avs_writedata_i[7:0];
            ADDR_MODEM_CONTROL: begin
               next_modem_control[4:0] = avs_writedata_i[4:0]; // RL13 RL14
               next_modem_control[MC_XANY] = avs_writedata_i[MC_XANY]; // RL17
               if (enhanced) begin
                  next_modem_control[MC_INFRARED] = avs_writedata_i[MC_INFRARED]; // RL18
                  next_modem_control[MC_PRESCALE] = avs_writedata_i[MC_PRESCALE]; // RL19
               end
            end
            ADDR_DIVISOR_LOW: next_divisor_low = avs_writedata_i[7:0]; // RL22
            ADDR_DIVISOR_HIGH: next_divisor_high = avs_writedata_i[7:0]; // RL22
            ADDR_MODE_CTRL: next_mode_ctrl = avs_writedata_i[7:0];
            ADDR_PRESCALER: next_prescaler = avs_writedata_i[7:0];
            default: next_line_err = next_line_err;
         endcase
      end
      // hardware sets, winning over any clear this cycle
      next_line_err = next_line_err | {events_i.brk, events_i.framing,
         events_i.parity, events_i.overrun}; // RL1
      // trigger zero waits for an idle line
      tx_set = events_i.tx_ttl_zero && mode_ctrl[MD_FINE_TRIG]
         ? (events_i.tx_fifo_empty && events_i.tx_shift_empty && tx_serial_i)
         : events_i.tx_level_lo; // RL6
      next_tx_set_prev = tx_set;
      // condition gone means writes refilled the fifo
      if (!tx_set) next_tx_flag = 1'b0; // RL5
      // set on the edge only, so a status read can clear it
      if (tx_set && !tx_set_prev) next_tx_flag = 1'b1; // RL5
      if (enhanced && (events_i.flow_stop || events_i.stop_two
          || events_i.nine_special))
         next_special_flag = 1'b1; // RL8
      // a pin rising low to high is its active-high bit falling
      if ((!lines[0] && modem_prev[0]) || (!modem_control[MC_RTS] && rts_prev))
         next_hs_flag = 1'b1; // RL9
      next_delta = next_delta | {lines[3] ^ modem_prev[3],
         modem_prev[2] & ~lines[2], lines[1] ^ modem_prev[1],
         lines[0] ^ modem_prev[0]}; // RL20
      next_readdata = {24'h000000, rd};
      next_waitrequest = !acc; // one-cycle answer, then release
      // pins: loopback idles everything high
      next_pins.dtr_n = loop | ~modem_control[MC_DTR]; // RL13 RL15
      next_pins.rts_n = loop | ~modem_control[MC_RTS]; // RL13 RL15
      next_pins.user_out_one_n = loop | modem_control[MC_USER_OUT_ONE_N]; // RL14 RL15
      next_pins.user_out_two_n = loop | modem_control[MC_USER_OUT_TWO_N]; // RL14 RL15
      next_pins.serial_out = loop | tx_serial_i; // RL15
      next_rx_serial = loop ? tx_serial_i : serial_in_i; // RL15
      next_irq = (pending != 7'h00);
      next_irq_oe = int_sel_n_i | modem_control[MC_USER_OUT_TWO_N]; // RL14
      if (srst_i) begin
         next_irq_enable = 8'h00;
         next_modem_control = 8'h00; // RL19
         next_mode_ctrl = 8'h00;
         next_divisor_low = DIVISOR_LOW_RESET; // RL22
         next_divisor_high = DIVISOR_HIGH_RESET;
         next_prescaler = PRESCALER_RESET; // RL19
         next_delta = 4'h0;
         next_line_err = 4'h0;
         next_tx_flag = 1'b0;
         next_special_flag = 1'b0;
         next_hs_flag = 1'b0;
         next_asleep = 1'b0;
         next_irq_code = CODE_NONE;
         next_modem_prev = 4'h0;
         next_rts_prev = 1'b0;
         next_tx_set_prev = 1'b0;
         next_readdata = 32'h00000000;
         next_waitrequest = 1'b1;
         next_pins = '1;
         next_rx_serial = 1'b1;
         next_irq = 1'b0;
         next_irq_oe = 1'b0;
      end
   end

   // register everything; asleep holds all state, only gating changes
   always_ff @(posedge ref_clk_i) begin
      irq_enable <= next_irq_enable;
      modem_control <= next_modem_control;
      mode_ctrl <= next_mode_ctrl;
      divisor_low <= next_divisor_low;
      divisor_high <= next_divisor_high;
      prescaler_setting <= next_prescaler;
      delta <= next_delta;
      line_err <= next_line_err;
      tx_flag <= next_tx_flag;
      special_flag <= next_special_flag;
      hs_flag <= next_hs_flag;
      asleep <= next_asleep; // RL11
      irq_code <= next_irq_code;
      modem_prev <= next_modem_prev;
      rts_prev <= next_rts_prev;
      tx_set_prev <= next_tx_set_prev;
      avs_readdata_o <= next_readdata;
      avs_waitrequest_o <= next_waitrequest;
      pins_o <= next_pins;
      rx_serial_o <= next_rx_serial;
      irq_o <= next_irq;
      irq_oe_o <= next_irq_oe;
      clk_gate_o <= !next_asleep; // RL10
      divisor_o <= {next_divisor_high, next_divisor_low}; // RL22
      prescaler_o <= next_prescaler;
      prescale_sel_o <= next_modem_control[MC_PRESCALE]; // RL19
      infrared_o <= next_modem_control[MC_INFRARED] && next_mode_ctrl[MD_ENHANCED]; // RL18
      auto_flow_o <= next_modem_control[MC_XANY] && !next_mode_ctrl[MD_ENHANCED]; // RL17
      xon_any_o <= next_modem_control[MC_XANY] && next_mode_ctrl[MD_ENHANCED]; // RL17
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   sequence msr_read_s;
      rd_acc && avs_address_i == ADDR_MODEM_STATUS && lines == modem_prev;
   endsequence
   delta_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      msr_read_s |=> delta == 4'h0) // RL20
      else $error("modem delta not cleared by status read");
   dtr_pin_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !loop |=> pins_o.dtr_n == !$past(modem_control[MC_DTR])) // RL13
      else $error("dtr pin wrong");
   loop_idle_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      loop |=> pins_o.serial_out && pins_o.rts_n) // RL15
      else $error("outputs not idle in loopback");
   code_none_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      pending == 7'h00 |=> irq_code == CODE_NONE) // RL24
      else $error("no interrupt code wrong");
   code_top_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      pending[0] |=> irq_code == CODE_RX_STATUS) // RL23
      else $error("level one not top priority");
   sleep_block_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      loop || modem_control[MC_INFRARED] |=> !asleep) // RL10
      else $error("sleep entered while blocked");
   wait_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low two cycles");
   prescale_keep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !enhanced |=> $stable(modem_control[MC_PRESCALE])) // RL19
      else $error("prescaler select changed outside enhanced");
   err_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      events_i.overrun |=> line_err[0]) // RL1
      else $error("overrun flag lost");
endmodule // uisc_ctrl

// ===== tb/uisc_modem_model.sv
`timescale 1ns/1ps
// far-end modem: four active-low handshake lines and an idle serial line
module uisc_modem_model (
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic ri_n_o,
   output logic dcd_n_o,
   output logic serial_o
);
   logic [3:0] lines = 4'hF; // dcd ri dsr cts, all inactive high
   assign {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = lines;
   assign serial_o = 1'b1; // no frames sent, so the line marks idle
   // lines move without regard to the channel clock phase
   task automatic set_lines(input logic [3:0] v);
      lines <= v;
   endtask
endmodule // uisc_modem_model

// ===== tb/test_uisc_ctrl.sv
`timescale 1ns/1ps
module test_uisc_ctrl;
   import uisc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   uisc_events_type ev = '0; // datapath quiet until a test drives it
   logic txs = 1'b1;
   logic isel_n = 1'b0;
   logic cts_n, dsr_n, ri_n, dcd_n, serial_in, rxs, irq, irq_oe, psel, ir, af, xa, gate;
   uisc_modem_pins_type pins;
   logic [15:0] dvs;
   logic [7:0] pre;
   int n_errors = 0;
   int tests_run = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   uisc_modem_model i_uisc_modem_model (.cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
      .dcd_n_o(dcd_n), .serial_o(serial_in));
   uisc_ctrl i_uisc_ctrl (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .events_i(ev), .tx_serial_i(txs), .serial_in_i(serial_in),
      .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .dcd_n_i(dcd_n), .int_sel_n_i(isel_n),
      .pins_o(pins), .rx_serial_o(rxs), .irq_o(irq), .irq_oe_o(irq_oe), .clk_gate_o(gate),
      .divisor_o(dvs), .prescaler_o(pre), .prescale_sel_o(psel), .infrared_o(ir),
      .auto_flow_o(af), .xon_any_o(xa));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // one avalon transfer; waitrequest and read data taken at one rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      adr <= a;
      wdat <= {24'h0, d};
      rd <= !w;
      wr <= w;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         conclude();
      end
   endtask
   // write, then let registered outputs settle
   task automatic wrr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic rdv(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check($sformatf("reg %0h", a), q & m, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic t_mcr();
      wrr(ADDR_MODEM_CONTROL, 8'h0F);
      check("pins", pins, 5'h07);
      check("irq_oe", irq_oe, 1'b1);
      wrr(ADDR_MODEM_CONTROL, 8'h03);
      check("pins", pins, 5'h01);
      check("irq_oe", irq_oe, 1'b0);
      isel_n <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      check("irq_oe", irq_oe, 1'b1);
      isel_n <= 1'b0;
      wrr(ADDR_DIVISOR_LOW, 8'h34);
      wrr(ADDR_DIVISOR_HIGH, 8'h12);
      check("divisor", dvs, 16'h1234);
      rdv(ADDR_DIVISOR_HIGH, 32'hFF, 32'h12);
   endtask
   // bits six and seven only move in enhanced mode
   task automatic t_mode();
      wrr(ADDR_MODEM_CONTROL, 8'hC0);
      rdv(ADDR_MODEM_CONTROL, 32'hFF, 32'h00);
      wrr(ADDR_MODE_CTRL, 8'h01);
      wrr(ADDR_MODEM_CONTROL, 8'hE0);
      check("prescale_sel", {psel, ir, xa, af}, 4'hE);
      wrr(ADDR_MODEM_CONTROL, 8'h00);
      wrr(ADDR_MODE_CTRL, 8'h00);
      wrr(ADDR_MODEM_CONTROL, 8'h20);
      check("auto_flow", {xa, af}, 2'h1);
   endtask
   task automatic t_msr();
      wrr(ADDR_IRQ_ENABLE, 8'h08);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_HANDSHAKE);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'h00);
      i_uisc_modem_model.set_lines(4'hE);
      repeat (6) @(posedge ref_clk_i);
      check("irq", irq, 1'b1);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_MODEM);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'h11);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'h10);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_NONE);
      i_uisc_modem_model.set_lines(4'hA);
      repeat (6) @(posedge ref_clk_i);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'h50);
      i_uisc_modem_model.set_lines(4'hE);
      repeat (6) @(posedge ref_clk_i);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'h14);
   endtask
   // one-cycle pulse on break, framing, parity, overrun
   task automatic err_pulse(input logic [3:0] v);
      {ev.brk, ev.framing, ev.parity, ev.overrun} <= v;
      @(posedge ref_clk_i);
      {ev.brk, ev.framing, ev.parity, ev.overrun} <= 4'h0;
      repeat (3) @(posedge ref_clk_i);
   endtask
   task automatic t_err();
      wrr(ADDR_IRQ_ENABLE, 8'h04);
      err_pulse(4'h1);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_RX_STATUS);
      rdv(ADDR_LINE_STATUS, 32'hFF, 32'h02);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_NONE);
      wrr(ADDR_MODE_CTRL, 8'h0A);
      err_pulse(4'h2);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_RX_STATUS);
      rdv(ADDR_LINE_STATUS, 32'hFF, 32'h04);
      err_pulse(4'h4);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_NONE);
      rdv(ADDR_LINE_STATUS, 32'hFF, 32'h88);
      wrr(ADDR_MODE_CTRL, 8'h00);
   endtask
   task automatic t_sleep();
      {ev.rx_idle, ev.tx_fifo_empty, ev.tx_shift_empty} <= 3'b111;
      wrr(ADDR_IRQ_ENABLE, 8'h28);
      check("clk_gate", gate, 1'b0);
      rdv(ADDR_IRQ_ENABLE, 32'hFF, 32'h28);
      ev.rx_idle <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      check("clk_gate", gate, 1'b1);
      ev.rx_idle <= 1'b1;
      wrr(ADDR_IRQ_ENABLE, 8'h08);
      check("clk_gate", gate, 1'b1);
   endtask
   task automatic t_loop();
      wrr(ADDR_MODEM_CONTROL, 8'h1F);
      txs <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      check("pins", pins, 5'h1F);
      check("rx_serial", rxs, 1'b0);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_MODEM);
      rdv(ADDR_MODEM_STATUS, 32'hFF, 32'hFA);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      check("reset", {dvs, pre}, {16'h0001, PRESCALER_RESET});
      check("pins", pins, 5'h1F);
      rdv(ADDR_IRQ_STATUS, 32'h3F, CODE_NONE);
      t_mcr();
      t_mode();
      t_msr();
      t_err();
      t_sleep();
      t_loop();
      conclude();
   end
endmodule // test_uisc_ctrl
